// ===== design/oxad_pkg.sv
// Package for the on-chip bus address decoder: windows, enables, timing and carriers.
// Assumes a 24-bit byte address space and a 16-bit data path.
package oxad_pkg;

  // ************************************************************
  // Address map
  // ************************************************************
  localparam logic [23:0] OXAD_SXRAM_LO   = 24'h00E000;
  localparam logic [23:0] OXAD_SXRAM_HI   = 24'h00E7FF;
  localparam logic [23:0] OXAD_LXRAM_LO   = 24'h00C000;
  localparam logic [23:0] OXAD_LXRAM_HI   = 24'h00DFFF;
  localparam logic [23:0] OXAD_NET1_LO    = 24'h00EF00;
  localparam logic [23:0] OXAD_NET1_HI    = 24'h00EFFF;
  localparam logic [23:0] OXAD_NET2_LO    = 24'h00EE00;
  localparam logic [23:0] OXAD_NET2_HI    = 24'h00EEFF;
  localparam int          OXAD_SFR_BYTES  = 1024;
  localparam int          OXAD_SFR_AREA   = 512;
  localparam int          OXAD_INTERNAL_DUAL_PORT_RAM_BYTES = 2048;
  localparam int          OXAD_BANK_REGS  = 16;

  // ************************************************************
  // Peripheral configuration fields and reset value
  // ************************************************************
  localparam int          OXAD_NET1_BIT   = 0;
  localparam int          OXAD_NET2_BIT   = 1;
  localparam int          OXAD_SXRAM_BIT  = 2;
  localparam int          OXAD_LXRAM_BIT  = 3;
  localparam int          OXAD_GLOBAL_BIT = 2;
  localparam logic [3:0]  OXAD_PCFG_RESET = 4'h5;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam logic [1:0]  OXAD_XRAM_WAITS = 2'h0;
  localparam logic [1:0]  OXAD_NET_WAITS  = 2'h2;
  localparam logic [3:0]  OXAD_SEG_FULL   = 4'h8;
  localparam logic [3:0]  OXAD_SEG_NET    = 4'h4;

  typedef enum logic [2:0] {
    OXAD_TGT_EXT,
    OXAD_TGT_SXRAM,
    OXAD_TGT_LXRAM,
    OXAD_TGT_NET1,
    OXAD_TGT_NET2
  } oxad_target_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  byte_en;
    logic [23:0] addr;
    logic [15:0] wdata;
  } oxad_req_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  byte_en;
    logic [23:0] addr;
    logic [15:0] wdata;
  } oxad_fwd_type;

endpackage : oxad_pkg

// ===== design/oxad_decoder.sv
// Address decoder that steers core accesses to on-chip extension RAM,
// the two network modules, or the external memory interface.
// Assumes one request at a time; the core holds a request until o_ready.
`timescale 1ns/1ns
`default_nettype none

module oxad_decoder
  import oxad_pkg::*;
(
  // Clock and reset
  input  wire logic      i_clk,
  input  wire logic      i_rst,
  // Configuration
  input  wire logic      i_global_enable,
  input  wire logic      i_pcfg_we,
  input  wire logic [3:0] i_pcfg_wdata,
  output logic [3:0]     o_pcfg,
  output logic [3:0]     o_seg_lines,
  // Core request
  input  wire oxad_req_type i_req,
  output logic           o_ready,
  output logic [15:0]    o_rdata,
  // On-chip targets
  output oxad_fwd_type   o_sxram,
  output oxad_fwd_type   o_lxram,
  output oxad_fwd_type   o_net1,
  output oxad_fwd_type   o_net2,
  input  wire logic [15:0] i_sxram_rdata,
  input  wire logic [15:0] i_lxram_rdata,
  input  wire logic [15:0] i_net1_rdata,
  input  wire logic [15:0] i_net2_rdata,
  // External memory interface
  output oxad_fwd_type   o_ext,
  input  wire logic      i_ext_ready,
  input  wire logic [15:0] i_ext_rdata
);

  // ************************************************************
  // Peripheral configuration
  // ************************************************************
  logic [3:0] pcfg_q;
  logic       pcfg_wr_ok;

  // Once the global enable is set the map is frozen so decode cannot move mid-run.
  assign pcfg_wr_ok = i_pcfg_we & ~i_global_enable;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pcfg_q <= OXAD_PCFG_RESET;
    end else if (pcfg_wr_ok) begin
      pcfg_q <= i_pcfg_wdata;
    end
  end

  assign o_pcfg = pcfg_q;

  // ************************************************************
  // Window decode
  // ************************************************************
  function automatic logic in_win(input logic [23:0] a, input logic [23:0] lo,
                                  input logic [23:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction : in_win

  wire logic sx_on = i_global_enable & pcfg_q[OXAD_SXRAM_BIT];
  wire logic lx_on = i_global_enable & pcfg_q[OXAD_LXRAM_BIT];
  wire logic n1_on = i_global_enable & pcfg_q[OXAD_NET1_BIT];
  wire logic n2_on = i_global_enable & pcfg_q[OXAD_NET2_BIT];

  wire logic hit_sx = in_win(i_req.addr, OXAD_SXRAM_LO, OXAD_SXRAM_HI) & sx_on;
  wire logic hit_lx = in_win(i_req.addr, OXAD_LXRAM_LO, OXAD_LXRAM_HI) & lx_on;
  wire logic hit_n1 = in_win(i_req.addr, OXAD_NET1_LO, OXAD_NET1_HI) & n1_on;
  wire logic hit_n2 = in_win(i_req.addr, OXAD_NET2_LO, OXAD_NET2_HI) & n2_on;

  // Anything not claimed on chip, including disabled windows, goes external.
  oxad_target_type tgt;
  assign tgt = hit_sx ? OXAD_TGT_SXRAM :
               hit_lx ? OXAD_TGT_LXRAM :
               hit_n1 ? OXAD_TGT_NET1  :
               hit_n2 ? OXAD_TGT_NET2  : OXAD_TGT_EXT;

  // Four segment lines when any network module is in use, eight otherwise.
  assign o_seg_lines = (n1_on | n2_on) ? OXAD_SEG_NET : OXAD_SEG_FULL;

  // ************************************************************
  // Wait-state sequencing
  // ************************************************************
  logic [1:0] wait_q;
  logic [1:0] wait_d;
  logic       net_tgt;
  logic       onchip_done;

  assign net_tgt = (tgt == OXAD_TGT_NET1) | (tgt == OXAD_TGT_NET2);
  // Extension RAM finishes in the request cycle; net modules after two waits.
  assign onchip_done = net_tgt ? (wait_q == OXAD_NET_WAITS)
                               : (wait_q == OXAD_XRAM_WAITS);
  assign wait_d = (i_req.valid & net_tgt & ~onchip_done) ? wait_q + 2'h1 : 2'h0;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_q <= 2'h0;
    end else begin
      wait_q <= wait_d;
    end
  end

  // ************************************************************
  // Forwarding and answer
  // ************************************************************
  function automatic oxad_fwd_type fwd(input oxad_req_type r, input logic sel);
    fwd.valid   = r.valid & sel;
    fwd.write   = r.write & sel;
    fwd.byte_en = sel ? r.byte_en : 2'h0;
    fwd.addr    = r.addr;
    fwd.wdata   = r.wdata;
  endfunction : fwd

  assign o_sxram = fwd(i_req, tgt == OXAD_TGT_SXRAM);
  assign o_lxram = fwd(i_req, tgt == OXAD_TGT_LXRAM);
  assign o_net1  = fwd(i_req, tgt == OXAD_TGT_NET1);
  assign o_net2  = fwd(i_req, tgt == OXAD_TGT_NET2);
  assign o_ext   = fwd(i_req, tgt == OXAD_TGT_EXT);

  wire logic [15:0] rdata_sel =
    (tgt == OXAD_TGT_SXRAM) ? i_sxram_rdata :
    (tgt == OXAD_TGT_LXRAM) ? i_lxram_rdata :
    (tgt == OXAD_TGT_NET1)  ? i_net1_rdata  :
    (tgt == OXAD_TGT_NET2)  ? i_net2_rdata  : i_ext_rdata;

  assign o_ready = i_req.valid & ((tgt == OXAD_TGT_EXT) ? i_ext_ready : onchip_done);

  // Read data is registered, so it is valid the cycle after o_ready.
  logic [15:0] rdata_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 16'h0000;
    end else if (o_ready & ~i_req.write) begin
      rdata_q <= rdata_sel;
    end
  end

  assign o_rdata = rdata_q;

endmodule : oxad_decoder

`default_nettype wire

// ===== test/oxad_assertions.sv
// Checker for the address decoder, bound to its top ports.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module oxad_checker
  import oxad_pkg::*;
(
  input wire logic         i_clk,
  input wire logic         i_rst,
  input wire logic         i_global_enable,
  input wire logic         i_pcfg_we,
  input wire logic [3:0]   o_pcfg,
  input wire logic [3:0]   o_seg_lines,
  input wire oxad_req_type i_req,
  input wire logic         o_ready,
  input wire oxad_fwd_type o_sxram,
  input wire oxad_fwd_type o_net1,
  input wire oxad_fwd_type o_ext,
  input wire logic         i_ext_ready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire logic sv = i_req.valid && i_req.addr >= OXAD_SXRAM_LO && i_req.addr <= OXAD_SXRAM_HI;
  wire logic nv = i_req.valid && i_req.addr >= OXAD_NET1_LO && i_req.addr <= OXAD_NET1_HI;
  wire logic son = i_global_enable && o_pcfg[OXAD_SXRAM_BIT];
  wire logic non = i_global_enable && o_pcfg[OXAD_NET1_BIT];
  wire logic [3:0] seg = (i_global_enable && |o_pcfg[1:0]) ? OXAD_SEG_NET : OXAD_SEG_FULL;
  sequence s_two_waits;
    !o_ready ##1 !o_ready;
  endsequence
  a_small_ram: assert property (sv && son |-> o_sxram.valid) else $error("small sel");
  a_small_ext: assert property (sv && !son |-> o_ext.valid) else $error("small ext");
  a_ram_no_wait: assert property (o_sxram.valid |-> o_ready) else $error("ram wait");
  a_net_sel: assert property (nv && non |-> o_net1.valid) else $error("net sel");
  a_net_waits: assert property ($rose(o_net1.valid) |-> s_two_waits ##1 o_ready)
    else $error("net wait");
  a_ext_done: assert property (o_ext.valid |-> o_ready == i_ext_ready)
    else $error("ext done");
  a_cfg_lock: assert property (i_global_enable && i_pcfg_we |=> $stable(o_pcfg))
    else $error("cfg lock");
  a_seg_lines: assert property (o_seg_lines == seg) else $error("seg lines");
endmodule : oxad_checker
bind oxad_decoder oxad_checker u_chk (.*);
`default_nettype wire

// ===== test/oxad_far_model.sv
// External memory model that answers after i_delay cycles.
// Assumes the decoder holds o_ext until it completes.
`timescale 1ns/1ns
`default_nettype none
module oxad_far_model
  import oxad_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [3:0]   i_delay,
  input  wire oxad_fwd_type i_ext,
  output logic              o_ext_ready,
  output logic [15:0]       o_ext_rdata
);
  logic [3:0] cnt_q;
  assign o_ext_ready = i_ext.valid && cnt_q == i_delay;
  // An idle bus shows the inverse, so stale data cannot pass for a read.
  assign o_ext_rdata = i_ext.valid ? i_ext.addr[15:0] ^ 16'hA5A5 : ~i_ext.addr[15:0];
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= (i_ext.valid && !o_ext_ready) ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule : oxad_far_model
`default_nettype wire

// ===== test/tb_onchip_xbus_address_decoder.sv
// Bench for the decoder: reads through each window under several enable settings.
// Assumes the external model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module tb_onchip_xbus_address_decoder
  import oxad_pkg::*;
;
  logic         i_clk, i_rst, i_global_enable, i_pcfg_we, o_ready, i_ext_ready;
  logic [3:0]   i_pcfg_wdata, o_pcfg, o_seg_lines, dly;
  logic [15:0]  o_rdata, i_ext_rdata;
  oxad_req_type i_req;
  oxad_fwd_type o_sxram, o_lxram, o_net1, o_net2, o_ext;
  int           failures = 0;
  int           checked = 0;
  // On-chip targets return fixed words 5A01..5A04 in target order.
  oxad_decoder uut (.*, .i_sxram_rdata(16'h5A01), .i_lxram_rdata(16'h5A02),
    .i_net1_rdata(16'h5A03), .i_net2_rdata(16'h5A04));
  oxad_far_model far (.i_clk(i_clk), .i_rst(i_rst), .i_delay(dly), .i_ext(o_ext),
    .o_ext_ready(i_ext_ready), .o_ext_rdata(i_ext_rdata));
  task automatic acc(input logic [23:0] a, input oxad_target_type t);
    int         n;
    logic [4:0] v;
    n = 0;
    i_req = '{1'b1, 1'b0, 2'h3, a, 16'h0};
    @(negedge i_clk);
    v = {o_net2.valid, o_net1.valid, o_lxram.valid, o_sxram.valid, o_ext.valid};
    `CHK("target", 5'h01 << t, v)
    while (o_ready !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    `CHK("waits", t == OXAD_TGT_EXT ? int'(dly) : (t >= OXAD_TGT_NET1 ? 2 : 0), n)
    @(posedge i_clk);
    #10;
    `CHK("rdata", t == OXAD_TGT_EXT ? a[15:0] ^ 16'hA5A5 : 16'h5A00 + t, o_rdata)
  endtask : acc
  task automatic cfg(input logic [3:0] d);
    i_req.valid = 1'b0;
    i_pcfg_we = 1'b1;
    i_pcfg_wdata = d;
    @(posedge i_clk);
    #10;
    i_pcfg_we = 1'b0;
  endtask : cfg
  task automatic print_verdict();
    if (failures == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    #100000;
    failures++;
    print_verdict();
  end
  initial begin
    i_rst = 1'b1;
    i_global_enable = 1'b0;
    i_pcfg_we = 1'b0;
    i_pcfg_wdata = 4'h0;
    i_req = '0;
    dly = 4'h3;
    repeat (12) @(posedge i_clk);
    #10;
    i_rst = 1'b0;
    `CHK("pcfg", OXAD_PCFG_RESET, o_pcfg)
    `CHK("seg", OXAD_SEG_FULL, o_seg_lines)
    acc(24'h00E000, OXAD_TGT_EXT);
    i_global_enable = 1'b1;
    dly = 4'h0;
    acc(24'h00DFFF, OXAD_TGT_EXT);
    acc(24'h00EE00, OXAD_TGT_EXT);
    i_req = '{1'b1, 1'b1, 2'h1, 24'h00EE10, 16'h1234};
    @(negedge i_clk);
    `CHK("net2 write", 1'b0, o_net2.write)
    `CHK("ext write", 1'b1, o_ext.write)
    `CHK("ext byte_en", 2'h1, o_ext.byte_en)
    @(posedge i_clk);
    #10;
    `CHK("rdata kept", 16'h00EE ^ 16'hA5A5 ^ 16'hEE00 ^ 16'h00EE, o_rdata)
    acc(24'h00F000, OXAD_TGT_EXT);
    acc(24'h00FA00, OXAD_TGT_EXT);
    acc(24'h00E7FF, OXAD_TGT_SXRAM);
    acc(24'h00EF00, OXAD_TGT_NET1);
    `CHK("seg", OXAD_SEG_NET, o_seg_lines)
    cfg(4'hF);
    `CHK("pcfg", OXAD_PCFG_RESET, o_pcfg)
    i_global_enable = 1'b0;
    #100;
    cfg(4'hF);
    i_global_enable = 1'b1;
    acc(24'h00C000, OXAD_TGT_LXRAM);
    acc(24'h00E800, OXAD_TGT_EXT);
    acc(24'h00EEFF, OXAD_TGT_NET2);
    print_verdict();
  end
endmodule : tb_onchip_xbus_address_decoder
`default_nettype wire
